// ==== rtl/arts_pkg.sv ====
// Constants, register map and carrier types of the asynchronous timer block
package arts_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADDR_COUNTER = 8'h00;
  localparam logic [7:0] ADDR_COMPARE = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_ASYNC   = 8'h0c;
  localparam logic [7:0] ADDR_MASK    = 8'h10;
  localparam logic [7:0] ADDR_FLAGS   = 8'h14;
  localparam logic [7:0] ADDR_SPECIAL = 8'h18;

  // Field positions
  localparam int ASYNC_SEL_BIT = 3;
  localparam int CNT_BUSY_BIT  = 2;
  localparam int CMP_BUSY_BIT  = 1;
  localparam int CTL_BUSY_BIT  = 0;
  localparam int CMP_IE_BIT    = 7;
  localparam int OVF_IE_BIT    = 6;
  localparam int CMP_FLAG_BIT  = 7;
  localparam int OVF_FLAG_BIT  = 6;
  localparam int PSR_BIT       = 1;
  localparam int CS_LSB        = 0;
  localparam int COM_LSB       = 4;

  // Holding register indices
  localparam int HOLD_CNT = 0;
  localparam int HOLD_CMP = 1;
  localparam int HOLD_CTL = 2;
  localparam int HOLD_NUM = 3;

  // Reset values and timing counts
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hff;
  localparam logic [1:0] HOLD_EDGES  = 2'h2;
  localparam logic [2:0] HALT_CYCLES = 3'h4;
  localparam int         PSC_WIDTH   = 10;

  typedef enum logic [2:0] {
    SLP_ACTIVE      = 3'h0,
    SLP_IDLE        = 3'h1,
    SLP_POWER_SAVE  = 3'h2,
    SLP_POWER_DOWN  = 3'h3,
    SLP_STANDBY     = 3'h4,
    SLP_EXT_STANDBY = 3'h5
  } arts_sleep_type;

  typedef enum logic [3:0] {
    WK_RUN   = 4'h1,
    WK_WAIT  = 4'h2,
    WK_HALT  = 4'h4,
    WK_REARM = 4'h8
  } arts_wake_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } arts_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } arts_wb_rsp_type;

endpackage

// ==== rtl/arts_timer.sv ====
// Asynchronous real time counter timer with holding registers and wake logic
`timescale 1ns/100ps
module arts_timer
  import arts_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  // Wishbone slave
  input  wire arts_wb_req_type wb_req,
  output arts_wb_rsp_type      wb_rsp,
  // Crystal and system
  input  wire logic            crystal_in_pin,
  input  wire logic            global_irq_enable,
  input  wire arts_sleep_type  sleep_mode,
  input  wire logic            compare_vec_ack,
  input  wire logic            overflow_vec_ack,
  // Requests and pins
  output logic                 compare_irq,
  output logic                 overflow_irq,
  output logic                 wake_req,
  output logic                 cpu_halt,
  output logic                 osc_enable,
  output logic                 port_detach,
  output logic                 compare_out
);

  logic [1:0]           xsync_r;
  logic                 xprev_r;
  logic                 xedge;
  logic                 async_r;
  logic                 src_tick;
  logic                 tick;
  logic [PSC_WIDTH-1:0] psc_r;
  logic                 psr_pend_r;
  logic                 psc_clear;
  logic [7:0]           cnt_r;
  logic [7:0]           cmp_r;
  logic [7:0]           ctl_r;
  logic [7:0]           shadow_r;
  logic [7:0]           hold_r [HOLD_NUM];
  logic [1:0]           ecnt_r [HOLD_NUM];
  logic [HOLD_NUM-1:0]  pend_r;
  logic [HOLD_NUM-1:0]  busy_r;
  logic [HOLD_NUM-1:0]  lat;
  logic [HOLD_NUM-1:0]  wr_hold;
  logic [2:0]           done_pipe_r [HOLD_NUM];
  logic [7:6]           mask_r;
  logic [7:6]           flags_r;
  logic [7:6]           evt_pipe_r [2];
  logic [7:6]           raw_evt;
  logic [7:6]           set_flag;
  logic                 cmp_raw;
  logic                 ovf_raw;
  logic                 ack_r;
  logic [31:0]          rdat_r;
  logic [7:0]           rd_val;
  logic                 wr;
  logic [7:0]           wdat;
  arts_wake_type        wake_r;
  logic [2:0]           halt_cnt_r;
  logic                 wake_cond;

  // Wishbone classic: ack one cycle after the strobe, write at the ack edge
  assign wr   = wb_req.cyc & wb_req.stb & ack_r & wb_req.we & wb_req.sel[0];
  assign wdat = wb_req.dat[7:0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
      if (wb_req.cyc && wb_req.stb && !ack_r) begin
        rdat_r <= {24'h00_0000, rd_val};
      end
    end
  end
  assign wb_rsp.ack = ack_r;
  assign wb_rsp.dat = rdat_r;
  always_comb begin
    if (wb_req.adr == ADDR_COUNTER) begin
      rd_val = shadow_r;
    end else if (wb_req.adr == ADDR_COMPARE) begin
      rd_val = hold_r[HOLD_CMP];
    end else if (wb_req.adr == ADDR_CONTROL) begin
      rd_val = hold_r[HOLD_CTL];
    end else if (wb_req.adr == ADDR_ASYNC) begin
      rd_val = {4'h0, async_r, busy_r[HOLD_CNT], busy_r[HOLD_CMP], busy_r[HOLD_CTL]};
    end else if (wb_req.adr == ADDR_MASK) begin
      rd_val = {mask_r, 6'h00};
    end else if (wb_req.adr == ADDR_FLAGS) begin
      rd_val = {flags_r, 6'h00};
    end else if (wb_req.adr == ADDR_SPECIAL) begin
      rd_val = {6'h00, psr_pend_r & async_r, 1'b0};
    end else begin
      rd_val = 8'h00;
    end
  end
  // Crystal input: first flop feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xsync_r <= 2'b00;
      xprev_r <= 1'b0;
    end else begin
      xsync_r <= {xsync_r[0], crystal_in_pin};
      xprev_r <= xsync_r[1];
    end
  end
  // Stopped oscillator gives no edges; contents after restart are not trusted
  assign xedge = xsync_r[1] & ~xprev_r & osc_enable;
  // Oscillator runs only in async mode and stops there in power-down and standby
  assign osc_enable  = async_r && sleep_mode != SLP_POWER_DOWN && sleep_mode != SLP_STANDBY;
  assign port_detach = async_r;
  assign src_tick    = async_r ? xedge : 1'b1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      async_r <= 1'b0;
      mask_r  <= 2'b00;
    end else if (wr && wb_req.adr == ADDR_ASYNC) begin
      async_r <= wdat[ASYNC_SEL_BIT];
    end else if (wr && wb_req.adr == ADDR_MASK) begin
      mask_r <= wdat[7:6];
    end
  end
  // Prescaler reset waits for a crystal edge when async, since the prescaler runs there
  assign psc_clear = psr_pend_r & (~async_r | xedge);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psr_pend_r <= 1'b0;
    end else if (wr && wb_req.adr == ADDR_SPECIAL && wdat[PSR_BIT]) begin
      psr_pend_r <= 1'b1;
    end else if (psc_clear) begin
      psr_pend_r <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      psc_r <= '0;
    end else if (psc_clear) begin
      psc_r <= '0;
    end else if (src_tick) begin
      psc_r <= psc_r + 1'b1;
    end
  end
  always_comb begin
    case (ctl_r[CS_LSB +: 3])
      3'h0:    tick = 1'b0;
      3'h1:    tick = src_tick;
      3'h2:    tick = src_tick & (&psc_r[2:0]);
      3'h3:    tick = src_tick & (&psc_r[4:0]);
      3'h4:    tick = src_tick & (&psc_r[5:0]);
      3'h5:    tick = src_tick & (&psc_r[6:0]);
      3'h6:    tick = src_tick & (&psc_r[7:0]);
      default: tick = src_tick & (&psc_r[9:0]);
    endcase
  end
  // Holding registers, one per destination
  assign wr_hold[HOLD_CNT] = wr && wb_req.adr == ADDR_COUNTER;
  assign wr_hold[HOLD_CMP] = wr && wb_req.adr == ADDR_COMPARE;
  assign wr_hold[HOLD_CTL] = wr && wb_req.adr == ADDR_CONTROL;
  for (genvar i = 0; i < HOLD_NUM; i++) begin : g_hold
    assign lat[i] = pend_r[i] & xedge & (ecnt_r[i] == HOLD_EDGES - 2'h1);
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        hold_r[i]      <= REG_RESET;
        ecnt_r[i]      <= 2'h0;
        pend_r[i]      <= 1'b0;
        busy_r[i]      <= 1'b0;
        done_pipe_r[i] <= 3'h0;
      end else begin
        done_pipe_r[i] <= {done_pipe_r[i][1:0], lat[i]};
        if (wr_hold[i]) begin
          hold_r[i] <= wdat;
          ecnt_r[i] <= 2'h0;
          pend_r[i] <= async_r;
          busy_r[i] <= async_r;
        end else begin
          if (pend_r[i] && xedge) begin
            ecnt_r[i] <= ecnt_r[i] + 2'h1;
          end
          if (lat[i]) begin
            pend_r[i] <= 1'b0;
          end
          if (done_pipe_r[i][2]) begin
            busy_r[i] <= 1'b0;
          end
        end
      end
    end
  end
  // Destinations: direct write when synchronous, latched copy when async
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= REG_RESET;
    end else if (lat[HOLD_CNT]) begin
      cnt_r <= hold_r[HOLD_CNT];
    end else if (wr_hold[HOLD_CNT] && !async_r) begin
      cnt_r <= wdat;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp_r <= REG_RESET;
      ctl_r <= REG_RESET;
    end else begin
      if (lat[HOLD_CMP] || (wr_hold[HOLD_CMP] && !async_r)) begin
        cmp_r <= lat[HOLD_CMP] ? hold_r[HOLD_CMP] : wdat;
      end
      if (lat[HOLD_CTL] || (wr_hold[HOLD_CTL] && !async_r)) begin
        ctl_r <= lat[HOLD_CTL] ? hold_r[HOLD_CTL] : wdat;
      end
    end
  end
  // A pending counter or compare value would give a false match
  assign cmp_raw = tick && cnt_r == cmp_r && !busy_r[HOLD_CNT] && !busy_r[HOLD_CMP];
  assign ovf_raw = tick && cnt_r == COUNT_MAX;
  // Shadow follows crystal edges only while the I/O clock runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_r <= REG_RESET;
    end else if (!async_r) begin
      shadow_r <= cnt_r;
    end else if (xedge && (sleep_mode == SLP_ACTIVE || sleep_mode == SLP_IDLE)) begin
      shadow_r <= cnt_r;
    end
  end
  // Compare pin driven straight from the raw compare match
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      compare_out <= 1'b0;
    end else if (cmp_raw) begin
      case (ctl_r[COM_LSB +: 2])
        2'h1:    compare_out <= ~compare_out;
        2'h2:    compare_out <= 1'b0;
        2'h3:    compare_out <= 1'b1;
        default: compare_out <= compare_out;
      endcase
    end
  end
  // Flags: async events cross two more stages, so set lands three cycles after the tick
  assign raw_evt = {cmp_raw, ovf_raw};
  assign set_flag = async_r ? evt_pipe_r[1] : raw_evt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_pipe_r[0] <= 2'b00;
      evt_pipe_r[1] <= 2'b00;
      flags_r       <= 2'b00;
    end else begin
      evt_pipe_r[0] <= raw_evt;
      evt_pipe_r[1] <= evt_pipe_r[0];
      for (int b = 6; b <= 7; b++) begin
        if (set_flag[b]) begin
          flags_r[b] <= 1'b1;
        end else if ((wr && wb_req.adr == ADDR_FLAGS && wdat[b]) ||
                     (b == CMP_FLAG_BIT ? compare_vec_ack : overflow_vec_ack)) begin
          flags_r[b] <= 1'b0;
        end
      end
    end
  end
  assign compare_irq  = flags_r[CMP_FLAG_BIT] & mask_r[CMP_IE_BIT] & global_irq_enable;
  assign overflow_irq = flags_r[OVF_FLAG_BIT] & mask_r[OVF_IE_BIT] & global_irq_enable;
  // Wake sequencer for power-save and extended standby
  assign wake_cond = async_r && (sleep_mode == SLP_POWER_SAVE || sleep_mode == SLP_EXT_STANDBY) &&
                     ((cmp_raw && mask_r[CMP_IE_BIT]) || (ovf_raw && mask_r[OVF_IE_BIT]));
  assign cpu_halt  = (wake_r == WK_HALT);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_r     <= WK_RUN;
      wake_req   <= 1'b0;
      halt_cnt_r <= 3'h0;
    end else begin
      wake_req <= 1'b0;
      case (wake_r)
        WK_RUN: begin
          if (wake_cond) begin
            wake_r <= WK_WAIT;
          end
        end
        WK_WAIT: begin
          if (xedge) begin
            wake_req   <= 1'b1;
            halt_cnt_r <= 3'h0;
            wake_r     <= WK_HALT;
          end
        end
        WK_HALT: begin
          halt_cnt_r <= halt_cnt_r + 3'h1;
          if (halt_cnt_r == HALT_CYCLES - 3'h1) begin
            wake_r <= WK_REARM;
          end
        end
        WK_REARM: begin
          // No new wake until a full crystal cycle resets the logic
          if (xedge) begin
            wake_r <= WK_RUN;
          end
        end
        default: wake_r <= WK_RUN;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_BUSY_SET: assert property (wr_hold[HOLD_CMP] && async_r |=> busy_r[HOLD_CMP] && pend_r[HOLD_CMP])
    else $error("compare busy did not set on async write");
  AST_LATCH_VALUE: assert property (lat[HOLD_CMP] |=> cmp_r == $past(hold_r[HOLD_CMP]))
    else $error("compare destination not latched from holding register");
  AST_INDEPENDENT: assert property (wr_hold[HOLD_CNT] && pend_r[HOLD_CMP] |=> $stable(hold_r[HOLD_CMP]))
    else $error("counter write disturbed compare holding register");
  AST_NO_MATCH_BUSY: assert property (busy_r[HOLD_CNT] || busy_r[HOLD_CMP] |-> !cmp_raw)
    else $error("compare match while update pending");
  AST_FLAG_SYNC: assert property ((cmp_raw && async_r) ##1 async_r [*2] |-> ##1 flags_r[CMP_FLAG_BIT])
    else $error("compare flag not visible three cycles after timer event");
  AST_GLOBAL_GATE: assert property (!global_irq_enable |-> !compare_irq && !overflow_irq)
    else $error("interrupt raised without global enable");
  AST_W1C: assert property (wr && wb_req.adr == ADDR_FLAGS && wdat[CMP_FLAG_BIT] && !set_flag[CMP_FLAG_BIT]
                            |=> !flags_r[CMP_FLAG_BIT])
    else $error("compare flag not cleared by written one");
  AST_OVF_SET: assert property (ovf_raw && !async_r |=> flags_r[OVF_FLAG_BIT])
    else $error("overflow flag not set on overflow");
  AST_HALT_FOUR: assert property ($rose(cpu_halt) |-> cpu_halt [*4] ##1 !cpu_halt)
    else $error("cpu halt not four cycles");
  AST_WAKE_EDGE: assert property (wake_req |-> $past(wake_r) == WK_WAIT && $past(xedge))
    else $error("wake not on the following timer edge");
  AST_PSR_HOLD: assert property (psr_pend_r && async_r && !xedge |=> psr_pend_r)
    else $error("prescaler reset bit cleared before crystal edge");
  AST_SHADOW_SLEEP: assert property (async_r && sleep_mode == SLP_POWER_SAVE |=> $stable(shadow_r))
    else $error("shadow changed while I/O clock asleep");
  COV_ASYNC_XFER: cover property (wr_hold[HOLD_CNT] && async_r ##[1:1000] $fell(busy_r[HOLD_CNT]));
  COV_WAKE: cover property (wake_req ##1 cpu_halt);
  COV_FLAG_IRQ: cover property ($rose(compare_irq));
  COV_PSR: cover property ($fell(psr_pend_r) && async_r);

endmodule

// ==== verification/arts_crystal_model.sv ====
// Watch crystal stand-in driving the timer oscillator pin
`timescale 1ns/100ps
module arts_crystal_model #(
  parameter int HALF_NS = 83
) (
  // Oscillator control
  input  wire logic osc_enable,
  // Crystal clock
  output logic      crystal_in_pin
);
  // Period well above four clk periods; odd half period keeps phase unrelated to clk
  initial begin
    crystal_in_pin = 1'b0;
    forever begin
      if (osc_enable === 1'b1) begin
        #(HALF_NS);
        crystal_in_pin = ~crystal_in_pin;
      end else begin
        // Stopped oscillator holds its level
        @(osc_enable);
      end
    end
  end
endmodule

// ==== verification/arts_timer_bench.sv ====
// Self-checking bench of the asynchronous timer block
`timescale 1ns/100ps
`define CHECK(got, exp) \
  begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module arts_timer_bench;
  import arts_pkg::*;
  logic            clk, resetn, global_irq_enable, compare_vec_ack, overflow_vec_ack;
  arts_wb_req_type wb_req;
  arts_wb_rsp_type wb_rsp;
  arts_sleep_type  sleep_mode;
  logic            crystal_in_pin, compare_irq, overflow_irq, wake_req, cpu_halt;
  logic            osc_enable, port_detach, compare_out;
  logic [7:0]      rd;
  int              n_errors, n_compared;

  arts_timer i_arts_timer (
    .clk(clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .crystal_in_pin(crystal_in_pin), .global_irq_enable(global_irq_enable),
    .sleep_mode(sleep_mode), .compare_vec_ack(compare_vec_ack),
    .overflow_vec_ack(overflow_vec_ack), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .wake_req(wake_req), .cpu_halt(cpu_halt),
    .osc_enable(osc_enable), .port_detach(port_detach), .compare_out(compare_out)
  );

  arts_crystal_model i_arts_crystal_model (
    .osc_enable(osc_enable), .crystal_in_pin(crystal_in_pin)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Request held until ack is sampled, then released for at least one cycle
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h000000, d}};
    // No assumed latency; a hang is ended by the watchdog
    do begin
      @(posedge clk);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    wb_xfer(1'b0, a, 8'h00);
    `CHECK(rd, e)
  endtask

  // Polls until no transfer is pending; software must not rewrite a busy register
  task automatic wait_not_busy();
    int k;
    k = 0;
    do begin
      wb_xfer(1'b0, ADDR_ASYNC, 8'h00);
      k++;
    end while (rd[2:0] !== 3'h0 && k < 200);
    `CHECK(rd[2:0], 3'h0)
  endtask

  task automatic t_reset();
    rdc(ADDR_MASK, 8'h00);
    rdc(ADDR_ASYNC, 8'h00);
    rdc(8'h40, 8'h00);
    `CHECK(port_detach, 1'b0)
  endtask

  task automatic t_sync_flags();
    wr(ADDR_MASK, 8'hc0);
    rdc(ADDR_MASK, 8'hc0);
    wr(ADDR_COMPARE, 8'h33);
    rdc(ADDR_COMPARE, 8'h33);
    rdc(ADDR_ASYNC, 8'h00);
    // Undivided count long enough to match and wrap
    wr(ADDR_CONTROL, 8'h01);
    repeat (300) @(posedge clk);
    wr(ADDR_CONTROL, 8'h00);
    rdc(ADDR_FLAGS, 8'hc0);
    global_irq_enable <= 1'b1;
    @(negedge clk);
    `CHECK({compare_irq, overflow_irq}, 2'b11)
    wr(ADDR_MASK, 8'h40);
    @(negedge clk);
    `CHECK({compare_irq, overflow_irq}, 2'b01)
    @(posedge clk);
    global_irq_enable <= 1'b0;
    @(negedge clk);
    `CHECK({compare_irq, overflow_irq}, 2'b00)
    @(posedge clk);
    compare_vec_ack <= 1'b1;
    @(posedge clk);
    compare_vec_ack <= 1'b0;
    rdc(ADDR_FLAGS, 8'h40);
    @(posedge clk);
    overflow_vec_ack <= 1'b1;
    @(posedge clk);
    overflow_vec_ack <= 1'b0;
    rdc(ADDR_FLAGS, 8'h00);
    // Second full wrap sets both flags again for the written-one clear
    wr(ADDR_CONTROL, 8'h01);
    repeat (300) @(posedge clk);
    wr(ADDR_CONTROL, 8'h00);
    rdc(ADDR_FLAGS, 8'hc0);
    wr(ADDR_FLAGS, 8'hc0);
    rdc(ADDR_FLAGS, 8'h00);
  endtask

  task automatic t_prescale();
    int div[6];
    div = '{8, 32, 64, 128, 256, 1024};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_COUNTER, 8'h00);
      wr(ADDR_SPECIAL, 8'h02);
      rdc(ADDR_SPECIAL, 8'h00);
      wr(ADDR_CONTROL, 8'(i + 2));
      repeat (div[i] * 10) @(posedge clk);
      wr(ADDR_CONTROL, 8'h00);
      wb_xfer(1'b0, ADDR_COUNTER, 8'h00);
      `CHECK(rd >= 8'h09 && rd <= 8'h0b, 1'b1)
      rdc(ADDR_COUNTER, rd);
    end
  endtask

  task automatic t_async();
    // Interrupts off before the clock source changes
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_ASYNC, 8'h08);
    rdc(ADDR_ASYNC, 8'h08);
    `CHECK(port_detach, 1'b1)
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      sleep_mode <= arts_sleep_type'(3'(m));
      @(negedge clk);
      `CHECK(osc_enable, !(m == 3 || m == 4))
    end
    // Prescaler reset stays pending while the stopped oscillator gives no edge
    @(posedge clk);
    sleep_mode <= SLP_POWER_DOWN;
    wr(ADDR_SPECIAL, 8'h02);
    rdc(ADDR_SPECIAL, 8'h02);
    @(posedge clk);
    sleep_mode <= SLP_ACTIVE;
    repeat (40) @(posedge clk);
    rdc(ADDR_SPECIAL, 8'h00);
    wr(ADDR_COMPARE, 8'h55);
    rdc(ADDR_ASYNC, 8'h0a);
    wr(ADDR_COUNTER, 8'h10);
    rdc(ADDR_ASYNC, 8'h0e);
    wait_not_busy();
    rdc(ADDR_COMPARE, 8'h55);
    repeat (40) @(posedge clk);
    rdc(ADDR_COUNTER, 8'h10);
  endtask

  task automatic t_wake();
    int k;
    int h;
    k = 0;
    h = 0;
    wr(ADDR_COMPARE, 8'h14);
    wr(ADDR_CONTROL, 8'h11);
    // Sleep only after the pending transfers land
    wait_not_busy();
    wr(ADDR_FLAGS, 8'hc0);
    wr(ADDR_MASK, 8'h80);
    global_irq_enable <= 1'b1;
    sleep_mode <= SLP_POWER_SAVE;
    do begin
      @(negedge clk);
      k++;
    end while (wake_req !== 1'b1 && k < 3000);
    `CHECK(wake_req, 1'b1)
    `CHECK(compare_out, 1'b1)
    // Halt begins in the cycle of the wake pulse, so counting starts there
    repeat (10) begin
      if (cpu_halt === 1'b1) h++;
      @(negedge clk);
    end
    `CHECK(h, 4)
    @(posedge clk);
    sleep_mode <= SLP_ACTIVE;
    // Control rewrite lets a crystal edge pass before the counter read
    wr(ADDR_CONTROL, 8'h11);
    wait_not_busy();
    wb_xfer(1'b0, ADDR_COUNTER, 8'h00);
    `CHECK(rd >= 8'h15, 1'b1)
    rdc(ADDR_FLAGS, 8'h80);
  endtask

  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly 16500 cycles the scenarios need
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    resetn = 1'b0;
    wb_req = '0;
    global_irq_enable = 1'b0;
    compare_vec_ack = 1'b0;
    overflow_vec_ack = 1'b0;
    sleep_mode = SLP_ACTIVE;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_sync_flags();
    t_prescale();
    t_async();
    t_wake();
    report_and_stop();
  end
endmodule
